/* logic/cdot_pkg.sv */
// Package: register map, field positions, reset values and filter lengths
package cdot_pkg;
  localparam int CDOT_AW = 4;
  localparam logic [3:0] CDOT_ADDR_CMP0_CTRL = 4'h0;
  localparam logic [3:0] CDOT_ADDR_CMP1_CTRL = 4'h1;
  localparam logic [3:0] CDOT_ADDR_CMP0_TRIM = 4'h2;
  localparam logic [3:0] CDOT_ADDR_CMP1_TRIM = 4'h3;
  localparam logic [3:0] CDOT_ADDR_HYST = 4'h4;
  localparam logic [3:0] CDOT_ADDR_POL = 4'h5;
  localparam logic [3:0] CDOT_ADDR_AMP0_TRIM = 4'h6;
  localparam logic [3:0] CDOT_ADDR_AMP1_TRIM = 4'h7;
  localparam logic [3:0] CDOT_ADDR_AMP_STAT = 4'h8;
  // Control register fields
  localparam int CDOT_CTL_RAW_BIT = 7;
  localparam int CDOT_CTL_ON_BIT = 6;
  localparam int CDOT_CTL_FILT_BIT = 5;
  localparam int CDOT_CTL_LEN_LSB = 2;
  localparam int CDOT_CTL_BIAS_LSB = 0;
  // Comparator trim fields
  localparam int CDOT_TRM_MODE_BIT = 6;
  localparam int CDOT_TRM_REF_BIT = 5;
  localparam logic [4:0] CDOT_CMP_TRIM_RST = 5'h10;
  // Amplifier trim fields
  localparam int CDOT_ATRM_MODE_BIT = 7;
  localparam int CDOT_ATRM_REF_BIT = 6;
  localparam logic [5:0] CDOT_AMP_TRIM_RST = 6'h20;
  // Hysteresis and polarity fields
  localparam int CDOT_HYS1_LSB = 2;
  localparam int CDOT_HYS0_LSB = 0;
  localparam int CDOT_POL0_BIT = 7;
  localparam int CDOT_POL1_BIT = 6;
  // Debounce thresholds in samples, one less than the history lengths
  localparam logic [6:0] CDOT_LEN_01 = 7'h1F;
  localparam logic [6:0] CDOT_LEN_10 = 7'h3F;
  localparam logic [6:0] CDOT_LEN_11 = 7'h7E;
  localparam logic [7:0] CDOT_RST_BYTE = 8'h00;

  typedef struct packed {
    logic on;
    logic invert;
    logic [1:0] filter_len;
  } cdot_chan_cfg_type;
endpackage

/* logic/cdot_debounce.sv */
// One comparator channel: gating, polarity, synchroniser, debounce, rise pulse
`timescale 1ns/1ps
module cdot_debounce
  import cdot_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic cmp_decision, // Analog decision, pos above neg
  input wire cdot_chan_cfg_type cfg, // Enable, invert, filter length
  output logic raw_result, // Synchronised raw result bit
  output logic filtered, // Debounced output
  output logic rise_irq // One-cycle pulse on filtered rise
);
  logic [2:0] sync_r;
  logic raw_r;
  logic filt_r;
  logic [6:0] run_r;
  logic [6:0] need;
  logic gated;

  // Disabled core output is low before the inverter
  assign gated = (cfg.on & cmp_decision) ^ cfg.invert;

  // Three-stage synchroniser; the first stage only feeds the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], gated};
    end
  end

  // A change counts once stages two and three agree; one-sample slivers die here
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      raw_r <= 1'h0;
    end else if (sync_r[2] == sync_r[1]) begin
      raw_r <= sync_r[2];
    end
  end
  assign raw_result = raw_r;

  always_comb begin
    unique case (cfg.filter_len)
      2'b01: need = CDOT_LEN_01;
      2'b10: need = CDOT_LEN_10;
      2'b11: need = CDOT_LEN_11;
      default: need = 7'h00;
    endcase
  end

  // Count of consecutive samples differing from output; flip once N+1 agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_r <= 7'h00;
      filt_r <= 1'b0;
    end else if (raw_r == filt_r) begin
      run_r <= 7'h00;
    end else if (run_r >= need) begin
      run_r <= 7'h00;
      filt_r <= raw_r;
    end else begin
      run_r <= run_r + 7'h01;
    end
  end
  assign filtered = filt_r;

  // Rise detector; a wider filter change only delays this
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rise_irq <= 1'b0;
    end else begin
      rise_irq <= (raw_r != filt_r) && (run_r >= need) && raw_r;
    end
  end
endmodule // cdot_debounce

/* logic/cdot_top.sv */
// Comparator debounce and offset trim control block top level
// Operation
// - Raw bit is comparison, inverted when polarity set
// - Disabled comparator output held low before polarity
// - Debounced output changes only after N+1 agreeing samples
// - Filter field selects none, 32, 64, 127 samples
// - Interrupt pulse on debounced rising edge only
// - Second comparator is an independent copy
// - Mode bit selects normal or offset calibration
// - Reference select picks negative or positive input
// - Five-bit trim field, writable, resets to 10000
// - Hysteresis register: cmp1 bits 3-2, cmp0 1-0
// - Unimplemented bits read as zero
// - Amplifier status follows core during calibration
// - Amplifier status reads zero outside calibration mode
// - Polarity bits 7 and 6 of separate register
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module cdot_top
  import cdot_pkg::*;
(
  input wire logic core_clk, // System clock, 40 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic cmp0_decision, // Comparator 0 core, pos above neg
  input wire logic cmp1_decision, // Comparator 1 core, pos above neg
  input wire logic amp0_decision, // Amplifier 0 core output
  input wire logic amp1_decision, // Amplifier 1 core output
  output logic cmp0_filtered, // Comparator 0 debounced output
  output logic cmp1_filtered, // Comparator 1 debounced output
  output logic cmp0_rise_irq, // Comparator 0 rise pulse
  output logic cmp1_rise_irq, // Comparator 1 rise pulse
  output logic cmp0_on, // Comparator 0 analog enable
  output logic cmp1_on, // Comparator 1 analog enable
  output logic [1:0] cmp0_bias_sel, // Comparator 0 current select
  output logic [1:0] cmp1_bias_sel, // Comparator 1 current select
  output logic cmp0_trim_mode, // Comparator 0 calibration mode
  output logic cmp1_trim_mode, // Comparator 1 calibration mode
  output logic cmp0_trim_ref_sel, // Comparator 0 reference select
  output logic cmp1_trim_ref_sel, // Comparator 1 reference select
  output logic [4:0] cmp0_trim_code, // Comparator 0 trim code
  output logic [4:0] cmp1_trim_code, // Comparator 1 trim code
  output logic [1:0] cmp0_hyst_sel, // Comparator 0 hysteresis
  output logic [1:0] cmp1_hyst_sel, // Comparator 1 hysteresis
  output logic [1:0] amp_trim_mode, // Amplifier calibration modes
  output logic [1:0] amp_trim_ref_sel, // Amplifier reference selects
  output logic [5:0] amp0_trim_code, // Amplifier 0 trim code
  output logic [5:0] amp1_trim_code // Amplifier 1 trim code
);
  logic cmp0_on_r;
  logic cmp1_on_r;
  logic [1:0] cmp0_len_r;
  logic [1:0] cmp1_len_r;
  logic [1:0] cmp0_bias_r;
  logic [1:0] cmp1_bias_r;
  logic cmp0_invert_r;
  logic cmp1_invert_r;
  logic [1:0] cmp_mode_r;
  logic [1:0] cmp_ref_r;
  logic [4:0] cmp0_code_r;
  logic [4:0] cmp1_code_r;
  logic [3:0] hyst_r;
  logic [1:0] amp_mode_r;
  logic [1:0] amp_ref_r;
  logic [5:0] amp0_code_r;
  logic [5:0] amp1_code_r;
  logic [2:0] amp0_sync_r;
  logic [2:0] amp1_sync_r;
  logic amp0_seen_r;
  logic amp1_seen_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_mux;
  logic cmp0_raw_result;
  logic cmp1_raw_result;
  cdot_chan_cfg_type cfg0;
  cdot_chan_cfg_type cfg1;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  // Comparator control registers; status bits are not writable
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmp0_on_r <= 1'b0;
      cmp0_len_r <= 2'h0;
      cmp0_bias_r <= 2'h0;
      cmp1_on_r <= 1'b0;
      cmp1_len_r <= 2'h0;
      cmp1_bias_r <= 2'h0;
    end else if (reg_wr) begin
      if (hit(reg_addr, CDOT_ADDR_CMP0_CTRL)) begin
        cmp0_on_r <= reg_wdata[CDOT_CTL_ON_BIT];
        cmp0_len_r <= reg_wdata[CDOT_CTL_LEN_LSB +: 2];
        cmp0_bias_r <= reg_wdata[CDOT_CTL_BIAS_LSB +: 2];
      end
      if (hit(reg_addr, CDOT_ADDR_CMP1_CTRL)) begin
        cmp1_on_r <= reg_wdata[CDOT_CTL_ON_BIT];
        cmp1_len_r <= reg_wdata[CDOT_CTL_LEN_LSB +: 2];
        cmp1_bias_r <= reg_wdata[CDOT_CTL_BIAS_LSB +: 2];
      end
    end
  end

  // Comparator trim registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmp_mode_r <= 2'h0;
      cmp_ref_r <= 2'h0;
      cmp0_code_r <= CDOT_CMP_TRIM_RST;
      cmp1_code_r <= CDOT_CMP_TRIM_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, CDOT_ADDR_CMP0_TRIM)) begin
        cmp_mode_r[0] <= reg_wdata[CDOT_TRM_MODE_BIT];
        cmp_ref_r[0] <= reg_wdata[CDOT_TRM_REF_BIT];
        cmp0_code_r <= reg_wdata[4:0];
      end
      if (hit(reg_addr, CDOT_ADDR_CMP1_TRIM)) begin
        cmp_mode_r[1] <= reg_wdata[CDOT_TRM_MODE_BIT];
        cmp_ref_r[1] <= reg_wdata[CDOT_TRM_REF_BIT];
        cmp1_code_r <= reg_wdata[4:0];
      end
    end
  end

  // Hysteresis and polarity registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hyst_r <= 4'h0;
      cmp0_invert_r <= 1'b0;
      cmp1_invert_r <= 1'b0;
    end else if (reg_wr) begin
      if (hit(reg_addr, CDOT_ADDR_HYST)) begin
        hyst_r <= reg_wdata[3:0];
      end
      if (hit(reg_addr, CDOT_ADDR_POL)) begin
        cmp0_invert_r <= reg_wdata[CDOT_POL0_BIT];
        cmp1_invert_r <= reg_wdata[CDOT_POL1_BIT];
      end
    end
  end

  // Amplifier trim registers; the sweep itself is firmware's job
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      amp_mode_r <= 2'h0;
      amp_ref_r <= 2'h0;
      amp0_code_r <= CDOT_AMP_TRIM_RST;
      amp1_code_r <= CDOT_AMP_TRIM_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, CDOT_ADDR_AMP0_TRIM)) begin
        amp_mode_r[0] <= reg_wdata[CDOT_ATRM_MODE_BIT];
        amp_ref_r[0] <= reg_wdata[CDOT_ATRM_REF_BIT];
        amp0_code_r <= reg_wdata[5:0];
      end
      if (hit(reg_addr, CDOT_ADDR_AMP1_TRIM)) begin
        amp_mode_r[1] <= reg_wdata[CDOT_ATRM_MODE_BIT];
        amp_ref_r[1] <= reg_wdata[CDOT_ATRM_REF_BIT];
        amp1_code_r <= reg_wdata[5:0];
      end
    end
  end

  // Amplifier outputs are asynchronous; three flops before reading
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      amp0_sync_r <= 3'h0;
      amp1_sync_r <= 3'h0;
    end else begin
      amp0_sync_r <= {amp0_sync_r[1:0], amp0_decision};
      amp1_sync_r <= {amp1_sync_r[1:0], amp1_decision};
    end
  end

  // Amplifier level counts once stages two and three agree; hides metastable slivers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      amp0_seen_r <= 1'h0;
      amp1_seen_r <= 1'h0;
    end else begin
      if (amp0_sync_r[2] == amp0_sync_r[1]) begin
        amp0_seen_r <= amp0_sync_r[2];
      end
      if (amp1_sync_r[2] == amp1_sync_r[1]) begin
        amp1_seen_r <= amp1_sync_r[2];
      end
    end
  end

  assign cfg0 = '{on: cmp0_on_r, invert: cmp0_invert_r, filter_len: cmp0_len_r};
  assign cfg1 = '{on: cmp1_on_r, invert: cmp1_invert_r, filter_len: cmp1_len_r};

  // Two identical channels
  cdot_debounce u_chan0 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cmp_decision(cmp0_decision),
    .cfg(cfg0),
    .raw_result(cmp0_raw_result),
    .filtered(cmp0_filtered),
    .rise_irq(cmp0_rise_irq)
  );

  cdot_debounce u_chan1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cmp_decision(cmp1_decision),
    .cfg(cfg1),
    .raw_result(cmp1_raw_result),
    .filtered(cmp1_filtered),
    .rise_irq(cmp1_rise_irq)
  );

  // Read mux; every unused bit is zero
  always_comb begin
    rd_mux = CDOT_RST_BYTE;
    unique case (reg_addr)
      CDOT_ADDR_CMP0_CTRL: begin
        rd_mux[CDOT_CTL_RAW_BIT] = cmp0_raw_result;
        rd_mux[CDOT_CTL_ON_BIT] = cmp0_on_r;
        rd_mux[CDOT_CTL_FILT_BIT] = cmp0_filtered;
        rd_mux[CDOT_CTL_LEN_LSB +: 2] = cmp0_len_r;
        rd_mux[CDOT_CTL_BIAS_LSB +: 2] = cmp0_bias_r;
      end
      CDOT_ADDR_CMP1_CTRL: begin
        rd_mux[CDOT_CTL_RAW_BIT] = cmp1_raw_result;
        rd_mux[CDOT_CTL_ON_BIT] = cmp1_on_r;
        rd_mux[CDOT_CTL_FILT_BIT] = cmp1_filtered;
        rd_mux[CDOT_CTL_LEN_LSB +: 2] = cmp1_len_r;
        rd_mux[CDOT_CTL_BIAS_LSB +: 2] = cmp1_bias_r;
      end
      CDOT_ADDR_CMP0_TRIM: begin
        rd_mux[CDOT_TRM_MODE_BIT] = cmp_mode_r[0];
        rd_mux[CDOT_TRM_REF_BIT] = cmp_ref_r[0];
        rd_mux[4:0] = cmp0_code_r;
      end
      CDOT_ADDR_CMP1_TRIM: begin
        rd_mux[CDOT_TRM_MODE_BIT] = cmp_mode_r[1];
        rd_mux[CDOT_TRM_REF_BIT] = cmp_ref_r[1];
        rd_mux[4:0] = cmp1_code_r;
      end
      CDOT_ADDR_HYST: rd_mux[3:0] = hyst_r;
      CDOT_ADDR_POL: begin
        rd_mux[CDOT_POL0_BIT] = cmp0_invert_r;
        rd_mux[CDOT_POL1_BIT] = cmp1_invert_r;
      end
      CDOT_ADDR_AMP0_TRIM: begin
        rd_mux[CDOT_ATRM_MODE_BIT] = amp_mode_r[0];
        rd_mux[CDOT_ATRM_REF_BIT] = amp_ref_r[0];
        rd_mux[5:0] = amp0_code_r;
      end
      CDOT_ADDR_AMP1_TRIM: begin
        rd_mux[CDOT_ATRM_MODE_BIT] = amp_mode_r[1];
        rd_mux[CDOT_ATRM_REF_BIT] = amp_ref_r[1];
        rd_mux[5:0] = amp1_code_r;
      end
      CDOT_ADDR_AMP_STAT: begin
        // Status only meaningful in calibration mode
        rd_mux[0] = amp_mode_r[0] & amp0_seen_r;
        rd_mux[1] = amp_mode_r[1] & amp1_seen_r;
      end
      default: rd_mux = CDOT_RST_BYTE;
    endcase
  end

  // Read data registered, valid the cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= CDOT_RST_BYTE;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= CDOT_RST_BYTE;
    end
  end
  assign reg_rdata = rdata_r;

  // Analog control outputs straight from registers
  assign cmp0_on = cmp0_on_r;
  assign cmp1_on = cmp1_on_r;
  assign cmp0_bias_sel = cmp0_bias_r;
  assign cmp1_bias_sel = cmp1_bias_r;
  assign cmp0_trim_mode = cmp_mode_r[0];
  assign cmp1_trim_mode = cmp_mode_r[1];
  assign cmp0_trim_ref_sel = cmp_ref_r[0];
  assign cmp1_trim_ref_sel = cmp_ref_r[1];
  assign cmp0_trim_code = cmp0_code_r;
  assign cmp1_trim_code = cmp1_code_r;
  assign cmp0_hyst_sel = hyst_r[CDOT_HYS0_LSB +: 2];
  assign cmp1_hyst_sel = hyst_r[CDOT_HYS1_LSB +: 2];
  assign amp_trim_mode = amp_mode_r;
  assign amp_trim_ref_sel = amp_ref_r;
  assign amp0_trim_code = amp0_code_r;
  assign amp1_trim_code = amp1_code_r;
endmodule // cdot_top

/* verif/cdot_analog_model.sv */
// Analog core model: commanded comparator levels, amplifier trim response
`timescale 1ns/1ps
module cdot_analog_model #(
  parameter logic [5:0] AMP0_EDGE = 6'h17, // Trip codes, arbitrary values
  parameter logic [5:0] AMP1_EDGE = 6'h28,
  parameter int AMP0_LAG = 2, // Settling cycles: one prompt, one slow
  parameter int AMP1_LAG = 7
) (
  input wire logic core_clk, // System clock
  input wire logic [1:0] cmp_level, // Commanded comparator levels
  input wire logic [5:0] amp0_trim_code, // Amplifier 0 trim
  input wire logic [5:0] amp1_trim_code, // Amplifier 1 trim
  output logic cmp0_decision, // Comparator 0 core
  output logic cmp1_decision, // Comparator 1 core
  output logic amp0_decision, // Amplifier 0 core
  output logic amp1_decision // Amplifier 1 core
);
  logic [7:0] amp0_sh_r;
  logic [7:0] amp1_sh_r;
  // Comparator cores follow the level at once, no settling
  assign cmp0_decision = cmp_level[0];
  assign cmp1_decision = cmp_level[1];
  // Low at code zero, high at all ones; settling delays the answer
  always_ff @(posedge core_clk) begin
    amp0_sh_r <= {amp0_sh_r[6:0], amp0_trim_code >= AMP0_EDGE};
    amp1_sh_r <= {amp1_sh_r[6:0], amp1_trim_code >= AMP1_EDGE};
  end
  assign amp0_decision = amp0_sh_r[AMP0_LAG];
  assign amp1_decision = amp1_sh_r[AMP1_LAG];
endmodule // cdot_analog_model

/* verif/cdot_properties.sv */
// Checker: register write effects, read timing and rise pulses
`timescale 1ns/1ps
module cdot_properties
  import cdot_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [3:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic cmp0_filtered, // Debounced 0
  input wire logic cmp1_filtered, // Debounced 1
  input wire logic cmp0_rise_irq, // Pulse 0
  input wire logic cmp1_rise_irq, // Pulse 1
  input wire logic cmp0_trim_mode, // Mode 0
  input wire logic cmp0_trim_ref_sel, // Reference 0
  input wire logic [4:0] cmp0_trim_code, // Trim 0
  input wire logic [1:0] cmp0_hyst_sel, // Hysteresis 0
  input wire logic [1:0] cmp1_hyst_sel, // Hysteresis 1
  input wire logic [1:0] amp_trim_mode, // Amplifier modes
  input wire logic [5:0] amp0_trim_code // Amplifier trim 0
);
  logic [7:0] wd_r;
  // Last cycle's write data, compared after the write lands
  always_ff @(posedge core_clk) begin
    wd_r <= reg_wdata;
  end
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_rise_pulse: assert property ($rose(cmp0_filtered) |-> cmp0_rise_irq)
    else $error("no pulse on rise 0");
  a_pulse_cause: assert property (cmp0_rise_irq |-> $rose(cmp0_filtered) ##1 !cmp0_rise_irq)
    else $error("bad pulse 0");
  a_pulse_cause1: assert property (cmp1_rise_irq |-> $rose(cmp1_filtered) ##1 !cmp1_rise_irq)
    else $error("bad pulse 1");
  a_trim_write: assert property (reg_wr && reg_addr == CDOT_ADDR_CMP0_TRIM |=>
    {cmp0_trim_mode, cmp0_trim_ref_sel, cmp0_trim_code} == wd_r[6:0])
    else $error("trim write lost");
  a_hyst_write: assert property (reg_wr && reg_addr == CDOT_ADDR_HYST |=>
    {cmp1_hyst_sel, cmp0_hyst_sel} == wd_r[3:0])
    else $error("hysteresis write lost");
  a_amp_write: assert property (reg_wr && reg_addr == CDOT_ADDR_AMP0_TRIM |=>
    {amp_trim_mode[0], amp0_trim_code} == {wd_r[7], wd_r[5:0]})
    else $error("amplifier trim write lost");
  a_trim_read: assert property (reg_rd && reg_addr == CDOT_ADDR_CMP0_TRIM |=>
    reg_rdata == {1'h0, cmp0_trim_mode, cmp0_trim_ref_sel, cmp0_trim_code})
    else $error("trim read wrong");
  a_status_off: assert property (reg_rd && reg_addr == CDOT_ADDR_AMP_STAT &&
    amp_trim_mode == 2'h0 |=> reg_rdata == 8'h00)
    else $error("status not zero outside calibration");
endmodule // cdot_properties

bind cdot_top cdot_properties i_props (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .cmp0_filtered, .cmp1_filtered, .cmp0_rise_irq, .cmp1_rise_irq,
  .cmp0_trim_mode, .cmp0_trim_ref_sel, .cmp0_trim_code, .cmp0_hyst_sel, .cmp1_hyst_sel,
  .amp_trim_mode, .amp0_trim_code);

/* verif/testbench.sv */
// Testbench: register map, comparator path, amplifier trim sweep
`timescale 1ns/1ps
module testbench;
  import cdot_pkg::*;
  localparam logic [5:0] EDGE0 = 6'h17; // Arbitrary trip codes
  localparam logic [5:0] EDGE1 = 6'h28;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [1:0] cmp_level = 2'h0;
  logic [7:0] reg_rdata;
  logic cmp0_decision, cmp1_decision, amp0_decision, amp1_decision;
  logic cmp0_filtered, cmp1_filtered, cmp0_rise_irq, cmp1_rise_irq;
  logic [4:0] cmp0_trim_code, cmp1_trim_code;
  logic cmp0_on, cmp1_on, cmp1_trim_mode, cmp1_trim_ref_sel;
  logic [1:0] cmp0_bias_sel, cmp1_bias_sel, amp_trim_ref_sel;
  logic [5:0] amp0_trim_code, amp1_trim_code;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  cdot_top i_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cmp0_decision, .cmp1_decision, .amp0_decision, .amp1_decision, .cmp0_filtered,
    .cmp1_filtered, .cmp0_rise_irq, .cmp1_rise_irq, .cmp0_on, .cmp1_on,
    .cmp0_bias_sel, .cmp1_bias_sel, .cmp0_trim_mode(), .cmp1_trim_mode,
    .cmp0_trim_ref_sel(), .cmp1_trim_ref_sel, .cmp0_trim_code, .cmp1_trim_code,
    .cmp0_hyst_sel(), .cmp1_hyst_sel(), .amp_trim_mode(), .amp_trim_ref_sel,
    .amp0_trim_code, .amp1_trim_code);
  cdot_analog_model #(.AMP0_EDGE(EDGE0), .AMP1_EDGE(EDGE1)) i_cores (.core_clk, .cmp_level,
    .amp0_trim_code, .amp1_trim_code, .cmp0_decision, .cmp1_decision, .amp0_decision,
    .amp1_decision);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles of the run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end
  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'h0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
  endtask
  // Bus cycles: strobe for one edge, read data taken in the next cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(d, e);
  endtask
  task automatic t_reset_values();
    logic [7:0] t [9] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h00, 8'h20, 8'h20, 8'h00};
    for (int a = 0; a < 16; a++) rdc(4'(a), a < 9 ? t[a] : 8'h00);
    $display("reset values done");
  endtask
  // All ones everywhere; status skipped, it depends on the cores
  task automatic t_write_all();
    logic [7:0] t [8] = '{8'h4F, 8'h4F, 8'h7F, 8'h7F, 8'h0F, 8'hC0, 8'hFF, 8'hFF};
    for (int a = 0; a < 16; a++) begin
      if (a != 8) begin
        wr(4'(a), 8'hFF);
        rdc(4'(a), a < 8 ? t[a] : 8'h00);
      end
    end
    check({3'h0, cmp0_trim_code}, 8'h1F);
    check({cmp1_on, cmp0_on, cmp1_bias_sel, cmp0_bias_sel, 2'h0}, 8'hFC);
    check({1'h0, cmp1_trim_mode, cmp1_trim_ref_sel, cmp1_trim_code}, 8'h7F);
    check({6'h00, amp_trim_ref_sel}, 8'h03);
    $display("write all done");
  endtask
  // Every enable, inversion and level; channels use opposite inversion
  task automatic t_polarity();
    logic on, inv, lvl, r0, r1;
    for (int i = 0; i < 8; i++) begin
      {lvl, inv, on} = 3'(i);
      r0 = (on & lvl) ^ inv;
      r1 = (on & lvl) ^ ~inv;
      wr(CDOT_ADDR_POL, {inv, ~inv, 6'h00});
      wr(CDOT_ADDR_CMP0_CTRL, {1'h0, on, 6'h00});
      wr(CDOT_ADDR_CMP1_CTRL, {1'h0, on, 6'h00});
      cmp_level <= {lvl, lvl};
      repeat (6) @(posedge core_clk);
      rdc(CDOT_ADDR_CMP0_CTRL, {r0, on, r0, 5'h00});
      rdc(CDOT_ADDR_CMP1_CTRL, {r1, on, r1, 5'h00});
    end
    $display("polarity done");
  endtask
  // Short glitch rejected, then exact rise and fall delays of the filter
  task automatic t_debounce(input logic [1:0] len, input int taps);
    int n;
    wr(CDOT_ADDR_POL, 8'h00);
    wr(CDOT_ADDR_CMP0_CTRL, {4'h4, len, 2'h0});
    wr(CDOT_ADDR_CMP1_CTRL, {4'h4, len, 2'h0});
    cmp_level <= 2'h0;
    repeat (taps + 8) @(posedge core_clk);
    if (taps > 1) begin
      cmp_level <= 2'h3;
      repeat (taps - 1) @(posedge core_clk);
      cmp_level <= 2'h0;
      repeat (taps + 8) @(posedge core_clk);
    end
    #1 check({6'h00, cmp1_filtered, cmp0_filtered}, 8'h00);
    @(posedge core_clk);
    cmp_level <= 2'h3;
    n = 0;
    while (cmp0_filtered !== 1'h1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    check(8'(n), 8'(taps + 4));
    check({4'h0, cmp1_rise_irq, cmp0_rise_irq, cmp1_filtered, cmp0_filtered}, 8'h0F);
    @(posedge core_clk);
    cmp_level <= 2'h0;
    #1 check({6'h00, cmp1_rise_irq, cmp0_rise_irq}, 8'h00);
    repeat (taps + 3) @(posedge core_clk);
    #1 check({6'h00, cmp1_filtered, cmp0_filtered}, 8'h03);
    @(posedge core_clk);
    #1 check({6'h00, cmp1_filtered, cmp0_filtered}, 8'h00);
    $display("debounce %0d done", taps);
  endtask
  task automatic probe(input logic [3:0] a, input int ch, input logic [5:0] c, output logic s);
    logic [7:0] d;
    wr(a, {2'h3, c});
    repeat (12) @(posedge core_clk);
    rd(CDOT_ADDR_AMP_STAT, d);
    check({d[7:2], 2'h0}, 8'h00);
    s = d[ch];
  endtask
  // Firmware sweep: up from zero, down from all ones, store the mean
  task automatic t_amp(input int ch, input logic [5:0] trip);
    logic [3:0] a;
    logic [5:0] c, lo, hi;
    logic s;
    a = ch ? CDOT_ADDR_AMP1_TRIM : CDOT_ADDR_AMP0_TRIM;
    wr(a, 8'h80);
    wr(a, 8'hC0);
    probe(a, ch, 6'h00, s);
    check({7'h00, s}, 8'h00);
    for (c = 6'h00; s === 1'h0 && c != 6'h3F; ) begin
      c++;
      probe(a, ch, c, s);
    end
    lo = c;
    probe(a, ch, 6'h3F, s);
    check({7'h00, s}, 8'h01);
    for (c = 6'h3F; s === 1'h1 && c != 6'h00; ) begin
      c--;
      probe(a, ch, c, s);
    end
    hi = c;
    check({2'h0, lo}, {2'h0, trip});
    check({2'h0, hi}, {2'h0, trip - 6'h01});
    wr(a, 8'h3F);
    repeat (12) @(posedge core_clk);
    rdc(CDOT_ADDR_AMP_STAT, 8'h00);
    wr(a, {2'h0, 6'((7'(lo) + 7'(hi)) >> 1)});
    #1 check({2'h0, ch ? amp1_trim_code : amp0_trim_code}, {2'h0, trip - 6'h01});
    $display("amplifier %0d sweep done", ch);
  endtask
  initial begin
    do_reset();
    t_reset_values();
    t_write_all();
    do_reset();
    t_reset_values();
    t_polarity();
    t_debounce(2'h0, 1);
    t_debounce(2'h1, 32);
    t_debounce(2'h2, 64);
    t_debounce(2'h3, 127);
    t_amp(0, EDGE0);
    t_amp(1, EDGE1);
    results();
  end
endmodule // testbench
